// *** rtl/nvm_pkg.sv ***
// Function
// (R01) Flash user area holds 8192 words of 14 bits, plus reserved words.
// (R02) Every read delivers exactly one memory word.
// (R03) Erase sets all bits to one; programming only clears bits.
// (R04) Flash rows are 32 words; a row is the smallest erase unit.
// (R05) Row data staged in hidden latches filled through data pair writes.
// (R06) Unprogrammed locations may be programmed without a row erase.
// (R07) Only row erase and write from software; no whole-array erase.
// (R08) EEPROM holds 256 bytes, each written individually.
// (R09) Indirect read stalls the CPU for the read, then releases it.
// (R10) Indirect high byte 70h selects EEPROM, low byte its address.
// (R11) Indirect writes never program or erase anything.
// (R12) Code protection blocks all register-port read, write and erase.
// (R13) Region bit clear selects flash; set selects ID, config, EEPROM.
// (R14) Read-start stalls CPU, fetches word next cycle, then self-clears.
// (R15) Data pair holds the word until next read or software write.
// (R16) Erase, latch load, program and EEPROM write need full unlock.
// (R17) Unlock: 55h, then AAh to unlock register, then write-start.
// (R18) Accepted flash operation stalls execution until it finishes.
// (R19) Software should disable interrupts around the unlock sequence.
// (R20) EEPROM write: region and write-allow set, address plus 7000h, unlock.
// (R21) EEPROM write erases the byte implicitly and runs in background.
// (R22) EEPROM done: clear write-start, set done flag, interrupt if enabled.
// (R23) Write-allow is never cleared by hardware after a write.
// (R24) Software clear of write-start during EEPROM write is ignored.
// (R25) Erase of write-protected flash clears write-start, erases nothing.
// (R26) Row erase: load row address, set erase and write-allow, unlock.
// (R27) Any break in unlock order resets the tracker.
// (R28) Write-start ignored while write-allow is clear.
package nvm_pkg;

  // ==========================================================
  // Geometry
  localparam int FLASH_WORDS = 8192;
  localparam int WORD_W      = 14;
  localparam int ROW_WORDS   = 32;
  localparam int ROW_AW      = 5;
  localparam int EE_BYTES    = 256;
  localparam int CFG_WORDS   = 16;
  localparam logic [7:0]  EE_PAGE   = 8'h70;
  localparam logic [13:0] WORD_ONES = 14'h3fff;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [4:0] ADR_CTRL   = 5'h00;
  localparam logic [4:0] ADR_KEY    = 5'h04;
  localparam logic [4:0] ADR_ADDR_L = 5'h08;
  localparam logic [4:0] ADR_ADDR_H = 5'h0c;
  localparam logic [4:0] ADR_DATA_L = 5'h10;
  localparam logic [4:0] ADR_DATA_H = 5'h14;
  localparam logic [4:0] ADR_STATUS = 5'h18;

  // ==========================================================
  // Control register bits
  localparam int B_RD    = 0;
  localparam int B_WR    = 1;
  localparam int B_WRITE_ALLOW = 2;
  localparam int B_FREE  = 4;
  localparam int B_LWLO  = 5;
  localparam int B_REGS  = 6;
  localparam int B_DONE  = 7;
  localparam int B_DIE   = 8;

  localparam logic [7:0] KEY_1 = 8'h55;
  localparam logic [7:0] KEY_2 = 8'haa;

  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int EE_WRITE_US  = 4000;
  localparam int EE_WRITE_CYC = EE_WRITE_US * (CLK_HZ / 1_000_000);
  localparam int FL_OP_US     = 2000;
  localparam int FL_OP_CYC    = FL_OP_US * (CLK_HZ / 1_000_000);

  typedef enum {
    UNLOCK_IDLE,
    UNLOCK_GOT55,
    UNLOCK_ARMED
  } unlock_t;

  typedef enum {
    OP_IDLE,
    OP_FLASH,
    OP_EE
  } op_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        valid;
  } ind_req_t;

endpackage

// *** rtl/nvm_ctrl.sv ***
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module nvm_ctrl #(
  parameter int EE_CYC = nvm_pkg::EE_WRITE_CYC,
  parameter int FL_CYC = nvm_pkg::FL_OP_CYC
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [4:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Indirect pointer read port
  input  wire nvm_pkg::ind_req_t ind_req_i,
  input  wire logic              ind_we_i,
  output logic      [13:0]       ind_data_o,
  // Protection and stall
  input  wire logic              code_protect_i,
  input  wire logic              write_protect_i,
  output logic                   cpu_stall_o,
  output logic                   done_irq_o
);

  // ==========================================================
  // Storage
  // (R01) (R08) array sizes
  localparam int ID_WORDS = 4;
  logic [13:0] flash_mem [nvm_pkg::FLASH_WORDS];
  logic [13:0] cfg_mem   [nvm_pkg::CFG_WORDS];
  logic [7:0]  ee_mem    [nvm_pkg::EE_BYTES];
  logic [13:0] latch     [nvm_pkg::ROW_WORDS];

  // ==========================================================
  // Registers
  logic                   rd_start;
  logic                   wr_start;
  logic                   write_allow;
  logic                   free_sel;
  logic                   latch_only;
  logic                   region_select;
  logic                   memory_done_flag;
  logic                   memory_done_int_en;
  logic [7:0]             address_low_reg;
  logic [6:0]             address_high_reg;
  logic [7:0]             data_low_reg;
  logic [5:0]             data_high_reg;
  nvm_pkg::unlock_t       unlock_state;
  nvm_pkg::op_t           op_state;
  logic [31:0]            op_cnt;
  logic [13:0]            ind_data;
  logic                   ind_busy;

  logic        wr_acc;
  logic        rd_acc;
  logic [14:0] addr;
  logic [13:0] fetch;
  logic        ee_sel;
  logic        accept_wr;
  logic        busy_ee;
  logic [4:0]  row_idx;
  logic [12:0] row_base;

  assign addr     = {address_high_reg, address_low_reg};
  assign wr_acc   = cyc_i && stb_i && we_i && !ack_o;
  assign rd_acc   = cyc_i && stb_i && !we_i && !ack_o;
  assign ee_sel   = region_select && (addr[14:8] == nvm_pkg::EE_PAGE[6:0]);
  assign busy_ee  = (op_state == nvm_pkg::OP_EE);
  assign row_idx  = addr[nvm_pkg::ROW_AW-1:0];
  assign row_base = {addr[12:nvm_pkg::ROW_AW], 5'h00};

  // (R13) region routing
  always_comb begin
    if (!region_select) begin
      fetch = flash_mem[addr[12:0]];
    end else if (ee_sel) begin
      fetch = {6'h00, ee_mem[addr[7:0]]};
    end else begin
      fetch = cfg_mem[addr[3:0]];
    end
  end

  // (R12) (R16) (R17) (R28) write-start acceptance
  assign accept_wr = wr_acc && (adr_i == nvm_pkg::ADR_CTRL) && sel_i[0]
                     && dat_i[nvm_pkg::B_WR] && !wr_start
                     && (unlock_state == nvm_pkg::UNLOCK_ARMED)
                     && write_allow && !code_protect_i;

  // ==========================================================
  // Bus acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (adr_i)
        nvm_pkg::ADR_CTRL: dat_o <= {23'h000000, memory_done_int_en,
          memory_done_flag, region_select, latch_only, free_sel, 1'b0,
          write_allow, wr_start, rd_start};
        nvm_pkg::ADR_ADDR_L: dat_o <= {24'h000000, address_low_reg};
        nvm_pkg::ADR_ADDR_H: dat_o <= {25'h0000000, address_high_reg};
        nvm_pkg::ADR_DATA_L: dat_o <= {24'h000000, data_low_reg};
        nvm_pkg::ADR_DATA_H: dat_o <= {26'h0000000, data_high_reg};
        nvm_pkg::ADR_STATUS: dat_o <= {30'h00000000,
          op_state != nvm_pkg::OP_IDLE, code_protect_i};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Unlock tracker
  // (R17) (R27) strict order, any other write disarms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_state <= nvm_pkg::UNLOCK_IDLE;
    end else if (wr_acc) begin
      if (adr_i == nvm_pkg::ADR_KEY && dat_i[7:0] == nvm_pkg::KEY_1) begin
        unlock_state <= nvm_pkg::UNLOCK_GOT55;
      end else if (adr_i == nvm_pkg::ADR_KEY
                   && dat_i[7:0] == nvm_pkg::KEY_2
                   && unlock_state == nvm_pkg::UNLOCK_GOT55) begin
        unlock_state <= nvm_pkg::UNLOCK_ARMED;
      end else begin
        unlock_state <= nvm_pkg::UNLOCK_IDLE;
      end
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_allow        <= 1'b0;
      free_sel           <= 1'b0;
      latch_only         <= 1'b0;
      region_select      <= 1'b0;
      memory_done_int_en <= 1'b0;
    end else if (wr_acc && adr_i == nvm_pkg::ADR_CTRL && sel_i[0]) begin
      // (R23) only software changes write-allow
      write_allow   <= dat_i[nvm_pkg::B_WRITE_ALLOW];
      free_sel      <= dat_i[nvm_pkg::B_FREE];
      latch_only    <= dat_i[nvm_pkg::B_LWLO];
      region_select <= dat_i[nvm_pkg::B_REGS];
      if (sel_i[1]) begin
        memory_done_int_en <= dat_i[nvm_pkg::B_DIE];
      end
    end
  end

  // Done flag: completion wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      memory_done_flag <= 1'b0;
    end else if (op_state != nvm_pkg::OP_IDLE && op_cnt == 32'd0) begin
      // (R22) completion flag
      memory_done_flag <= 1'b1;
    end else if (wr_acc && adr_i == nvm_pkg::ADR_CTRL && sel_i[0]) begin
      memory_done_flag <= dat_i[nvm_pkg::B_DONE];
    end
  end

  assign done_irq_o = memory_done_flag && memory_done_int_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      address_low_reg  <= 8'h00;
      address_high_reg <= 7'h00;
    end else if (wr_acc && sel_i[0]) begin
      if (adr_i == nvm_pkg::ADR_ADDR_L) begin
        address_low_reg <= dat_i[7:0];
      end
      if (adr_i == nvm_pkg::ADR_ADDR_H) begin
        address_high_reg <= dat_i[6:0];
      end
    end
  end

  // ==========================================================
  // Read-start and data pair
  // (R14) (R12) fetch in one cycle, bit clears itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_start <= 1'b0;
    end else if (rd_start) begin
      rd_start <= 1'b0;
    end else if (wr_acc && adr_i == nvm_pkg::ADR_CTRL && sel_i[0]
                 && !code_protect_i) begin
      rd_start <= dat_i[nvm_pkg::B_RD];
    end
  end

  // (R15) (R02) pair holds one word until next read or write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_low_reg  <= 8'h00;
      data_high_reg <= 6'h00;
    end else if (rd_start) begin
      data_low_reg  <= fetch[7:0];
      data_high_reg <= fetch[13:8];
    end else if (wr_acc && sel_i[0]) begin
      if (adr_i == nvm_pkg::ADR_DATA_L) begin
        data_low_reg <= dat_i[7:0];
      end
      if (adr_i == nvm_pkg::ADR_DATA_H) begin
        data_high_reg <= dat_i[5:0];
      end
    end
  end

  // ==========================================================
  // Write engine
  // (R18) (R21) (R24) (R25) operation sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_state <= nvm_pkg::OP_IDLE;
      op_cnt   <= 32'd0;
      wr_start <= 1'b0;
    end else begin
      case (op_state)
        nvm_pkg::OP_IDLE: begin
          if (accept_wr) begin
            if (ee_sel) begin
              op_state <= nvm_pkg::OP_EE;
              op_cnt   <= 32'(EE_CYC - 1);
              wr_start <= 1'b1;
            end else if (latch_only && !free_sel) begin
              // Latch load is immediate, no array access
              wr_start <= 1'b0;
            end else if (write_protect_i && !region_select) begin
              wr_start <= 1'b0;
            end else if (region_select && free_sel) begin
              // Config area erase is not offered to software
              wr_start <= 1'b0;
            end else begin
              op_state <= nvm_pkg::OP_FLASH;
              op_cnt   <= 32'(FL_CYC - 1);
              wr_start <= 1'b1;
            end
          end
        end
        nvm_pkg::OP_FLASH, nvm_pkg::OP_EE: begin
          if (op_cnt == 32'd0) begin
            op_state <= nvm_pkg::OP_IDLE;
            wr_start <= 1'b0;
          end else begin
            op_cnt <= op_cnt - 32'd1;
          end
        end
        default: op_state <= nvm_pkg::OP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Array updates
  // (R05) (R06) latch loaded from data pair on an unlocked write
  // Unloaded latches hold ones, so a program leaves their words intact
  always_ff @(posedge clk_i) begin
    if (rst_i || (op_state == nvm_pkg::OP_FLASH && op_cnt == 32'd0
                  && !free_sel)) begin
      for (int i = 0; i < nvm_pkg::ROW_WORDS; i++) begin
        latch[i] <= nvm_pkg::WORD_ONES;
      end
    end else if (accept_wr && !ee_sel && latch_only && !free_sel) begin
      latch[row_idx] <= {data_high_reg, data_low_reg};
    end
  end

  // (R03) (R06) erase to ones, program clears bits only
  logic [13:0] row_next [nvm_pkg::ROW_WORDS];
  for (genvar w = 0; w < nvm_pkg::ROW_WORDS; w++) begin : g_row
    assign row_next[w] = free_sel ? nvm_pkg::WORD_ONES
                         : flash_mem[row_base + 13'(w)] & latch[w];
  end

  // (R04) (R07) one row at a time, never the whole array
  // One writer for the flash and config arrays keeps them single-driven
  always_ff @(posedge clk_i) begin
    if (op_state == nvm_pkg::OP_FLASH && op_cnt == 32'd0) begin
      if (!region_select) begin
        for (int i = 0; i < nvm_pkg::ROW_WORDS; i++) begin
          flash_mem[row_base + 13'(i)] <= row_next[i];
        end
      end else if (!free_sel && addr[3:0] < 4'(ID_WORDS)) begin
        for (int i = 0; i < ID_WORDS; i++) begin
          cfg_mem[i] <= cfg_mem[i] & latch[i];
        end
      end
    end
  end

  // (R08) (R21) byte write with implicit erase
  always_ff @(posedge clk_i) begin
    if (busy_ee && op_cnt == 32'd0) begin
      ee_mem[addr[7:0]] <= data_low_reg;
    end
  end

  // ==========================================================
  // Indirect read path
  // (R09) (R10) (R11) one-cycle stall, read-only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_busy <= 1'b0;
      ind_data <= 14'h0000;
    end else if (ind_req_i.valid && !ind_we_i && !ind_busy) begin
      ind_busy <= 1'b1;
      if (ind_req_i.addr[15:8] == nvm_pkg::EE_PAGE) begin
        ind_data <= {6'h00, ee_mem[ind_req_i.addr[7:0]]};
      end else begin
        ind_data <= flash_mem[ind_req_i.addr[12:0]];
      end
    end else begin
      ind_busy <= 1'b0;
    end
  end

  assign ind_data_o  = ind_data;
  assign cpu_stall_o = rd_start || (op_state == nvm_pkg::OP_FLASH)
                       || (ind_req_i.valid && !ind_we_i && !ind_busy);

endmodule

// *** verif/cpu_model.sv ***
`timescale 1ns/1ps
module cpu_model (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Bench command
  input  wire logic         go_i,
  input  wire logic         we_i,
  input  wire logic [15:0]  addr_i,
  output logic              busy_o,
  output logic      [13:0]  word_o,
  // Toward the controller
  input  wire logic         stall_i,
  input  wire logic [13:0]  ind_data_i,
  output nvm_pkg::ind_req_t ind_req_o,
  output logic              ind_we_o
);
  assign busy_o = ind_req_o.valid;

  // ==========================================================
  // Pointer access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_req_o <= '{addr: 16'hffff, valid: 1'b0};
      ind_we_o  <= 1'b0;
    end else if (go_i && !ind_req_o.valid) begin
      ind_req_o <= '{addr: addr_i, valid: 1'b1};
      ind_we_o  <= we_i;
    end else if (ind_req_o.valid && !stall_i) begin
      word_o    <= ind_data_i;
      // Released lines show the inverse, never the old value
      ind_req_o <= '{addr: ~ind_req_o.addr, valid: 1'b0};
      ind_we_o  <= ~ind_we_o;
    end
  end
endmodule

// *** verif/nvm_ctrl_asserts.sv ***
`timescale 1ns/1ps
module nvm_ctrl_asserts #(
  parameter int EE_CYC = 8,
  parameter int FL_CYC = 8
) (
  // Clock, reset and bus
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [4:0]        adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  // Pointer port, protection, stall
  input wire nvm_pkg::ind_req_t ind_req_i,
  input wire logic              ind_we_i,
  input wire logic [13:0]       ind_data_o,
  input wire logic              code_protect_i,
  input wire logic              write_protect_i,
  input wire logic              cpu_stall_o,
  input wire logic              done_irq_o
);
  logic       req;
  logic       cw;
  logic       go;
  logic [1:0] key;
  logic [7:0] scnt;

  assign req = cyc_i & stb_i & we_i & !ack_o;
  assign cw  = req & (adr_i == nvm_pkg::ADR_CTRL);
  assign go  = cw & dat_i[1] & dat_i[2] & (key == 2'h2) & !code_protect_i;

  // ==========================================================
  // Mirror of the unlock tracker; any other write breaks it
  always_ff @(posedge clk_i) begin
    key <= (rst_i | (req & adr_i != nvm_pkg::ADR_KEY)) ? 2'h0 :
           !req ? key :
           (dat_i[7:0] == nvm_pkg::KEY_1) ? 2'h1 :
           (dat_i[7:0] == nvm_pkg::KEY_2 && key == 2'h1) ? 2'h2 : 2'h0;
  end
  always_ff @(posedge clk_i) begin
    scnt <= (rst_i | !cpu_stall_o) ? 8'h0 : scnt + 8'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet;
    !cpu_stall_o [*4];
  endsequence
  sequence s_ind;
    cpu_stall_o ##1 !cpu_stall_o;
  endsequence

  property p_ind;
    $rose(ind_req_i.valid) && !ind_we_i |-> s_ind;
  endproperty
  property p_rd;
    cw && dat_i[0] && !code_protect_i |-> ##[1:3] cpu_stall_o;
  endproperty
  property p_cp;
    cw && code_protect_i |=> s_quiet;
  endproperty
  property p_lock;
    cw && dat_i[1] && key != 2'h2 |=> s_quiet;
  endproperty
  property p_write_allow;
    cw && dat_i[1] && !dat_i[2] |=> s_quiet;
  endproperty
  property p_fl;
    go && !dat_i[6] && !dat_i[5] && !write_protect_i |-> ##[1:3] cpu_stall_o;
  endproperty
  property p_ee;
    go && dat_i[6] |=> s_quiet;
  endproperty
  property p_len;
    cpu_stall_o |-> scnt <= FL_CYC + 4;
  endproperty

  a_ind: assert property (p_ind) else $error("pointer stall");
  a_rd: assert property (p_rd) else $error("read stall");
  a_cp: assert property (p_cp) else $error("protect");
  a_lock: assert property (p_lock) else $error("unlock");
  a_write_allow: assert property (p_write_allow) else $error("allow bit");
  a_fl: assert property (p_fl) else $error("flash stall");
  a_ee: assert property (p_ee) else $error("ee stall");
  a_len: assert property (p_len) else $error("stall long");
endmodule

bind nvm_ctrl nvm_ctrl_asserts #(.EE_CYC(EE_CYC), .FL_CYC(FL_CYC)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ind_req_i(ind_req_i), .ind_we_i(ind_we_i), .ind_data_o(ind_data_o),
  .code_protect_i(code_protect_i), .write_protect_i(write_protect_i),
  .cpu_stall_o(cpu_stall_o), .done_irq_o(done_irq_o)
);

// *** verif/test_nonvolatile_memory_access.sv ***
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) begin \
      fail_count++; \
      $display("MISMATCH %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module test_nonvolatile_memory_access;
  logic              clk, rst, cyc, stb, we, ack, cp, wp;
  logic              ind_we, stall, irq, go, cwe, cbusy;
  logic [4:0]        adr;
  logic [31:0]       wdat, rdat, q;
  logic [13:0]       ind_data, word, w;
  logic [15:0]       caddr;
  nvm_pkg::ind_req_t ind_req;
  int                fail_count = 0;
  int                n_checks = 0;

  // Long write time so the busy window can be probed
  nvm_ctrl #(.EE_CYC(40), .FL_CYC(8)) i_dut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .ind_req_i(ind_req), .ind_we_i(ind_we), .ind_data_o(ind_data),
    .code_protect_i(cp), .write_protect_i(wp), .cpu_stall_o(stall),
    .done_irq_o(irq)
  );
  cpu_model i_cpu (
    .clk_i(clk), .rst_i(rst), .go_i(go), .we_i(cwe), .addr_i(caddr),
    .busy_o(cbusy), .word_o(word), .stall_i(stall), .ind_data_i(ind_data),
    .ind_req_o(ind_req), .ind_we_o(ind_we)
  );

  // ==========================================================
  // Bus and sequence helpers
  task automatic wb(input logic w_en, input logic [4:0] a,
                    input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w_en;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && n++ < 50);
    `CHK(ack, 1'b1)
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic unlock(input int bad);
    // keys in order, nothing may interrupt them
    wb(1'b1, nvm_pkg::ADR_KEY, {24'h0, nvm_pkg::KEY_1});
    if (bad == 1) wb(1'b1, nvm_pkg::ADR_KEY, 32'h11);
    if (bad == 2) wb(1'b1, nvm_pkg::ADR_STATUS, 32'h0);
    wb(1'b1, nvm_pkg::ADR_KEY, {24'h0, nvm_pkg::KEY_2});
  endtask
  task automatic setw(input logic [15:0] a, input logic [13:0] d);
    wb(1'b1, nvm_pkg::ADR_ADDR_L, {24'h0, a[7:0]});
    wb(1'b1, nvm_pkg::ADR_ADDR_H, {24'h0, a[15:8]});
    wb(1'b1, nvm_pkg::ADR_DATA_L, {24'h0, d[7:0]});
    wb(1'b1, nvm_pkg::ADR_DATA_H, {26'h0, d[13:8]});
  endtask
  task automatic fetch(input logic [31:0] rg, input logic [15:0] a);
    setw(a, 14'h0);
    wb(1'b1, nvm_pkg::ADR_CTRL, rg | 32'h1);
    wb(1'b0, nvm_pkg::ADR_DATA_L, 32'h0);
    w[7:0] = q[7:0];
    wb(1'b0, nvm_pkg::ADR_DATA_H, 32'h0);
    w[13:8] = q[5:0];
  endtask
  task automatic poll;
    int n = 0;
    q = 32'h2;
    while (q[1] !== 1'b0 && n++ < 100) wb(1'b0, nvm_pkg::ADR_CTRL, 32'h0);
    `CHK(q[1], 1'b0)
  endtask
  task automatic run(input logic [31:0] c, input int bad);
    wb(1'b1, nvm_pkg::ADR_CTRL, c & ~32'h2);
    unlock(bad);
    wb(1'b1, nvm_pkg::ADR_CTRL, c);
    poll;
  endtask
  task automatic ind(input logic [15:0] a, input logic w_en);
    int n = 0;
    @(posedge clk);
    go    <= 1'b1;
    caddr <= a;
    cwe   <= w_en;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    while (cbusy !== 1'b0 && n++ < 50) @(negedge clk);
    `CHK(cbusy, 1'b0)
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_ee;
    setw({nvm_pkg::EE_PAGE, 8'h05}, 14'h05a);
    wb(1'b1, nvm_pkg::ADR_CTRL, 32'h44);
    unlock(0);
    wb(1'b1, nvm_pkg::ADR_CTRL, 32'h46);
    // Clearing the start bit mid-write must not stop it
    wb(1'b1, nvm_pkg::ADR_CTRL, 32'h44);
    wb(1'b0, nvm_pkg::ADR_CTRL, 32'h0);
    `CHK(q[1], 1'b1)
    poll;
    `CHK(q[7:6], 2'h3)
    `CHK(q[2], 1'b1)
    `CHK(irq, 1'b0)
    wb(1'b1, nvm_pkg::ADR_CTRL, 32'h1c4);
    `CHK(irq, 1'b1)
    wb(1'b1, nvm_pkg::ADR_CTRL, 32'h84);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_rd;
    ind({nvm_pkg::EE_PAGE, 8'h05}, 1'b0);
    `CHK(word[7:0], 8'h5a)
    ind({nvm_pkg::EE_PAGE, 8'h05}, 1'b1);
    ind({nvm_pkg::EE_PAGE, 8'h05}, 1'b0);
    `CHK(word[7:0], 8'h5a)
    fetch(32'h40, {nvm_pkg::EE_PAGE, 8'h05});
    `CHK(w[7:0], 8'h5a)
  endtask
  task automatic t_fl;
    // row address, erase and allow bits
    setw(16'h0040, 14'h0);
    run(32'h16, 0);
    fetch(32'h0, 16'h0041);
    `CHK(w, nvm_pkg::WORD_ONES)
    fetch(32'h0, 16'h005f);
    `CHK(w, nvm_pkg::WORD_ONES)
    setw(16'h0041, 14'h2a5c);
    run(32'h26, 0);
    run(32'h06, 0);
    setw(16'h0043, 14'h1111);
    run(32'h26, 0);
    run(32'h06, 0);
    fetch(32'h0, 16'h0041);
    `CHK(w, 14'h2a5c)
    fetch(32'h0, 16'h0042);
    `CHK(w, nvm_pkg::WORD_ONES)
    fetch(32'h0, 16'h0043);
    `CHK(w, 14'h1111)
  endtask
  task automatic t_guard;
    for (int k = 1; k < 5; k++) begin
      @(posedge clk);
      wp <= (k == 4);
      setw(16'h0041, 14'h0);
      run(k == 3 ? 32'h12 : 32'h16, k < 3 ? k : 0);
      fetch(32'h0, 16'h0041);
      `CHK(w, 14'h2a5c)
    end
    @(posedge clk);
    wp <= 1'b0;
  endtask
  task automatic t_cp;
    setw(16'h0041, 14'h0133);
    @(posedge clk);
    cp <= 1'b1;
    wb(1'b1, nvm_pkg::ADR_CTRL, 32'h1);
    wb(1'b0, nvm_pkg::ADR_DATA_L, 32'h0);
    `CHK(q[7:0], 8'h33)
    wb(1'b0, nvm_pkg::ADR_STATUS, 32'h0);
    `CHK(q[0], 1'b1)
    run(32'h16, 0);
    @(posedge clk);
    cp <= 1'b0;
    fetch(32'h0, 16'h0041);
    `CHK(w, 14'h2a5c)
    wb(1'b0, 5'h1c, 32'h0);
    `CHK(q, 32'h0)
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run is under a thousand cycles; the 30,000-cycle limit is over thirty times that
  initial begin
    #3_000_000;
    fail_count++;
    close_out;
  end
  initial begin
    {rst, cyc, stb, we, cp, wp, go, cwe} = 8'h80;
    adr   = 5'h0;
    wdat  = 32'h0;
    caddr = 16'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_ee;
    t_rd;
    t_fl;
    t_guard;
    t_cp;
    close_out;
  end
endmodule
